// ---- rtl/an_pd_ctrl.sv ----
// auto-negotiation, parallel detection and carrier/collision control
`timescale 1ns/100ps
module an_pd_ctrl
    import an_pd_pkg::*;
#(
    parameter int          BREAK_CYCLES   = an_pd_pkg::BREAK_CYC,
    parameter int          BURST_CYCLES   = an_pd_pkg::BURST_CYC,
    parameter int          TIMEOUT_CYCLES = an_pd_pkg::TIMEOUT_CYC,
    parameter logic [3:0]  ADV_DEFAULT    = an_pd_pkg::ADV_RST
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        pdn_reset_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    input  wire logic        rx_word_valid_i,
    input  wire logic [15:0] rx_word_i,
    input  wire logic        nlp_detect_i,
    input  wire logic        mlt3_detect_i,
    input  wire logic        rx_signal_i,
    input  wire logic        tx_en_i,
    input  wire logic        rx_active_i,
    output logic             tx_pulse_o,
    output logic             link_up_o,
    output logic             speed100_o,
    output logic             full_duplex_o,
    output logic             an_done_o,
    output logic             crs_o,
    output logic             col_o
);
    import an_pd_pkg::*;

    typedef struct packed {
        an_st_type    st;
        logic         an_en;
        logic         spd_sel;
        logic         dpx_sel;
        logic [3:0]   adv;
        logic [15:0]  lp;
        logic         lp_an;
        logic         pd_fault;
        logic         an_done;
        logic         spd;
        logic         dpx;
        logic         link;
        logic [24:0]  tmr;
        logic [18:0]  gap;
        logic [10:0]  sub;
        logic [5:0]   slot;
        logic [1:0]   mcnt;
        logic         seen;
        logic         pulse;
        logic         crs;
        logic         col;
        logic [15:0]  rdata;
    } state_type;

    localparam state_type RST_S = '{st: ST_ABIL, an_en: ANEN_RST, spd_sel: SPD_RST, dpx_sel: DPX_RST,
                                    adv: ADV_DEFAULT, lp: 16'h0000, lp_an: 1'b0, pd_fault: 1'b0,
                                    an_done: 1'b0, spd: 1'b0, dpx: 1'b0, link: 1'b0, tmr: 25'h0000000,
                                    gap: 19'h00000, sub: 11'h000, slot: 6'h21, mcnt: 2'h0, seen: 1'b0,
                                    pulse: 1'b0, crs: 1'b0, col: 1'b0, rdata: 16'h0000};
    localparam logic [24:0] BRK_END  = 25'(BREAK_CYCLES - 1);
    localparam logic [24:0] TMO_END  = 25'(TIMEOUT_CYCLES - 1);
    localparam logic [18:0] GAP_END  = 19'(BURST_CYCLES - 1);
    localparam logic [10:0] SUB_END  = 11'(SLOT_CYC - 1);
    localparam logic [5:0]  SLOT_NUM = 6'(BURST_SLOTS);
    localparam logic [1:0]  MCNT_END = 2'(MATCH_NEED - 1);

    state_type   s_ff;
    state_type   nxt_s;
    logic [15:0] txw;
    logic [3:0]  com;
    logic        go_abil;
    logic        ctrl_wr;

    ////////////////////////////////////////////////////////////////////////////
    // sent word: no next page, no remote fault
    assign txw = {1'b0, s_ff.st == ST_ACK, 1'b0, 4'h0, s_ff.adv, SEL_8023};
    assign com = s_ff.adv & s_ff.lp[8:5];
    assign ctrl_wr = wr_i && addr_i == REG_CTRL;

    always_comb begin
        nxt_s = s_ff;
        go_abil = 1'b0;
        nxt_s.pulse = 1'b0;
        nxt_s.rdata = 16'h0000;

        // register reads; fault bit latches high and clears on read
        if (rd_i) begin
            case (addr_i)
                REG_CTRL: nxt_s.rdata = {2'b00, s_ff.spd_sel, s_ff.an_en, 3'b000, s_ff.dpx_sel, 8'h00};
                REG_STAT: nxt_s.rdata = {10'h000, s_ff.an_done, 1'b0, 1'b1, s_ff.link, 2'b00};
                REG_ADV:  nxt_s.rdata = {7'h00, s_ff.adv, SEL_8023};
                REG_LPA:  nxt_s.rdata = s_ff.lp;
                REG_EXP: begin
                    nxt_s.rdata = {11'h000, s_ff.pd_fault, 3'b000, s_ff.lp_an};
                    nxt_s.pd_fault = 1'b0;
                end
                REG_SPEC: nxt_s.rdata = {3'b000, s_ff.an_done, 7'h00, s_ff.dpx, s_ff.spd, ~s_ff.spd, 2'b00};
                default:  nxt_s.rdata = 16'h0000;
            endcase
        end

        // burst generator runs only while negotiating
        if (s_ff.st == ST_ABIL || s_ff.st == ST_ACK) begin
            nxt_s.gap = (s_ff.gap == GAP_END) ? 19'h00000 : s_ff.gap + 19'h00001;
            if (s_ff.gap == GAP_END) begin
                nxt_s.slot = 6'h00;
                nxt_s.sub = 11'h000;
            end else if (s_ff.slot < SLOT_NUM) begin
                nxt_s.sub = (s_ff.sub == SUB_END) ? 11'h000 : s_ff.sub + 11'h001;
                if (s_ff.sub == SUB_END)
                    nxt_s.slot = s_ff.slot + 6'h01;
                // even slots frame, odd slot k carries data bit k/2
                if (s_ff.sub == 11'h000)
                    nxt_s.pulse = ~s_ff.slot[0] | txw[s_ff.slot[4:1]];
            end
        end else begin
            nxt_s.gap = 19'h00000;
            nxt_s.slot = SLOT_NUM;
        end

        case (s_ff.st)
            ST_FORCED: begin
                nxt_s.link = rx_signal_i;
                nxt_s.spd = s_ff.spd_sel;
                nxt_s.dpx = s_ff.dpx_sel;
                nxt_s.an_done = 1'b0;
            end
            ST_BREAK: begin
                nxt_s.link = 1'b0;
                nxt_s.tmr = s_ff.tmr + 25'h0000001;
                if (s_ff.tmr == BRK_END)
                    go_abil = 1'b1;
            end
            ST_ABIL: begin
                if (rx_word_valid_i) begin
                    nxt_s.tmr = 25'h0000000;
                    nxt_s.seen = 1'b1;
                    nxt_s.lp_an = 1'b1;
                    nxt_s.lp = rx_word_i;
                    if (s_ff.seen && rx_word_i == s_ff.lp) begin
                        nxt_s.mcnt = s_ff.mcnt + 2'h1;
                        if (s_ff.mcnt == MCNT_END) begin
                            nxt_s.st = ST_ACK;
                            nxt_s.mcnt = 2'h0;
                        end
                    end else begin
                        // a fresh word is already the first of the identical run
                        nxt_s.mcnt = 2'h1;
                    end
                end else if (!s_ff.seen && nlp_detect_i && mlt3_detect_i) begin
                    nxt_s.pd_fault = 1'b1;
                end else if (!s_ff.seen && (nlp_detect_i || mlt3_detect_i)) begin
                    // parallel detection: speed from the line, half duplex
                    nxt_s.st = ST_LINK;
                    nxt_s.link = 1'b1;
                    nxt_s.an_done = 1'b1;
                    nxt_s.spd = mlt3_detect_i;
                    nxt_s.dpx = 1'b0;
                    nxt_s.lp_an = 1'b0;
                    nxt_s.lp = {7'h00, mlt3_detect_i ? TA_100HD : TA_10HD, SEL_8023};
                end else if (s_ff.seen) begin
                    nxt_s.tmr = s_ff.tmr + 25'h0000001;
                    if (s_ff.tmr == TMO_END)
                        go_abil = 1'b1;
                end
            end
            ST_ACK: begin
                if (rx_word_valid_i) begin
                    nxt_s.tmr = 25'h0000000;
                    if (rx_word_i[13:0] != s_ff.lp[13:0]) begin
                        go_abil = 1'b1;
                    end else if (rx_word_i[LCW_ACK]) begin
                        nxt_s.mcnt = s_ff.mcnt + 2'h1;
                        if (s_ff.mcnt == MCNT_END) begin
                            nxt_s.st = ST_LINK;
                            nxt_s.link = 1'b1;
                            nxt_s.an_done = 1'b1;
                            // control speed/duplex bits play no part here
                            if (com[3]) begin
                                nxt_s.spd = 1'b1;
                                nxt_s.dpx = 1'b1;
                            end else if (com[2]) begin
                                nxt_s.spd = 1'b1;
                                nxt_s.dpx = 1'b0;
                            end else if (com[1]) begin
                                nxt_s.spd = 1'b0;
                                nxt_s.dpx = 1'b1;
                            end else if (com[0]) begin
                                nxt_s.spd = 1'b0;
                                nxt_s.dpx = 1'b0;
                            end else begin
                                go_abil = 1'b1;
                            end
                        end
                    end
                end else begin
                    nxt_s.tmr = s_ff.tmr + 25'h0000001;
                    if (s_ff.tmr == TMO_END)
                        go_abil = 1'b1;
                end
            end
            ST_LINK: begin
                if (!rx_signal_i)
                    go_abil = 1'b1;
            end
            default: go_abil = 1'b1;
        endcase

        if (pdn_reset_i && s_ff.an_en)
            go_abil = 1'b1;

        if (go_abil) begin
            nxt_s.st = ST_ABIL;
            nxt_s.tmr = 25'h0000000;
            nxt_s.mcnt = 2'h0;
            nxt_s.seen = 1'b0;
            nxt_s.link = 1'b0;
            nxt_s.an_done = 1'b0;
        end

        // software writes take priority over the negotiation flow
        if (wr_i && addr_i == REG_ADV)
            nxt_s.adv = wdata_i[8:5];
        if (ctrl_wr) begin
            nxt_s.an_en = wdata_i[CTRL_ANEN];
            nxt_s.spd_sel = wdata_i[CTRL_SPD];
            nxt_s.dpx_sel = wdata_i[CTRL_DPX];
            if (!wdata_i[CTRL_ANEN]) begin
                nxt_s.st = ST_FORCED;
            end else if (wdata_i[CTRL_RSTRT]) begin
                // hold everything quiet long enough for the partner to drop too
                nxt_s.st = ST_BREAK;
                nxt_s.tmr = 25'h0000000;
                nxt_s.link = 1'b0;
                nxt_s.an_done = 1'b0;
                nxt_s.seen = 1'b0;
                nxt_s.mcnt = 2'h0;
            end else if (!s_ff.an_en) begin
                nxt_s.st = ST_ABIL;
                nxt_s.tmr = 25'h0000000;
                nxt_s.seen = 1'b0;
                nxt_s.mcnt = 2'h0;
                nxt_s.link = 1'b0;
            end
            if (wdata_i[CTRL_SRST]) begin
                nxt_s = RST_S;
                nxt_s.adv = ADV_DEFAULT;
            end
        end

        nxt_s.crs = rx_active_i | (tx_en_i & ~s_ff.dpx);
        nxt_s.col = tx_en_i & rx_active_i & ~s_ff.dpx;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            s_ff <= RST_S;
        else
            s_ff <= nxt_s;
    end

    assign rdata_o       = s_ff.rdata;
    assign tx_pulse_o    = s_ff.pulse;
    assign link_up_o     = s_ff.link;
    assign speed100_o    = s_ff.spd;
    assign full_duplex_o = s_ff.dpx;
    assign an_done_o     = s_ff.an_done;
    assign crs_o         = s_ff.crs;
    assign col_o         = s_ff.col;

    ////////////////////////////////////////////////////////////////////////////
    chk_word_fields: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rd_i && addr_i == REG_ADV |=> rdata_o[4:0] == SEL_8023 && rdata_o[8:5] == $past(s_ff.adv))
        else $error("advertised word fields wrong");

    chk_ack_bit: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ACK && $past(s_ff.st) == ST_ABIL
        |-> $past(rx_word_valid_i && s_ff.seen && rx_word_i == s_ff.lp && s_ff.mcnt == MCNT_END))
        else $error("acknowledge entered without match");

    chk_ack_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ACK && rx_word_valid_i && rx_word_i[13:0] != s_ff.lp[13:0] && !wr_i
        |=> s_ff.st == ST_ABIL && !s_ff.link)
        else $error("changed word did not restart");

    chk_restart_break: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ctrl_wr && wdata_i[CTRL_ANEN] && wdata_i[CTRL_RSTRT] && !wdata_i[CTRL_SRST]
        |=> s_ff.st == ST_BREAK && !s_ff.link ##1 !s_ff.pulse)
        else $error("restart did not enter break");

    chk_break_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ABIL && $past(s_ff.st) == ST_BREAK |-> $past(s_ff.tmr) == BRK_END)
        else $error("break timer cut short");

    chk_best_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ACK && rx_word_valid_i && rx_word_i[LCW_ACK] && rx_word_i[13:0] == s_ff.lp[13:0]
        && s_ff.mcnt == MCNT_END && com[3] && !wr_i && !pdn_reset_i
        |=> s_ff.spd && s_ff.dpx && s_ff.link && s_ff.st == ST_LINK)
        else $error("resolution not highest mode");

    chk_forced_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_FORCED ##1 s_ff.st == ST_FORCED
        |-> s_ff.spd == $past(s_ff.spd_sel) && s_ff.dpx == $past(s_ff.dpx_sel))
        else $error("forced mode not applied");

    chk_pd_link: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ABIL && !s_ff.seen && !rx_word_valid_i && (nlp_detect_i ^ mlt3_detect_i)
        && !wr_i && !pdn_reset_i
        |=> s_ff.link && !s_ff.dpx && !s_ff.lp_an && s_ff.spd == $past(mlt3_detect_i))
        else $error("parallel detect link wrong");

    chk_pd_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_ABIL && !s_ff.seen && !rx_word_valid_i && nlp_detect_i && mlt3_detect_i
        && !(wr_i && addr_i == REG_CTRL) |=> s_ff.pd_fault)
        else $error("fault bit not set");

    chk_loss_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_LINK && !rx_signal_i && !ctrl_wr |=> s_ff.st == ST_ABIL && !s_ff.link)
        else $error("no restart on signal loss");

    chk_col_dup: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.col |-> $past(tx_en_i && rx_active_i && !s_ff.dpx))
        else $error("collision in full duplex");

    chk_crs_rx: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rx_active_i |=> s_ff.crs)
        else $error("carrier sense missed");

    // full duplex must not raise carrier on our own transmit
    chk_fdx_crs: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.dpx && !rx_active_i |=> !s_ff.crs)
        else $error("carrier raised by transmit in full duplex");

    chk_quiet_break: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_ff.st == ST_BREAK |=> !s_ff.pulse)
        else $error("pulse sent during break");

    chk_rstrt_reads0: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rd_i && addr_i == REG_CTRL |=> !rdata_o[CTRL_RSTRT] && !rdata_o[CTRL_SRST])
        else $error("self clearing bit reads one");

    chk_adv_no_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_i && addr_i == REG_ADV && s_ff.st == ST_LINK && rx_signal_i && !pdn_reset_i
        |=> s_ff.st == ST_LINK && s_ff.link)
        else $error("advertisement write restarted");

    chk_enable_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ctrl_wr && !wdata_i[CTRL_ANEN] && !wdata_i[CTRL_SRST] |=> s_ff.st == ST_FORCED && !s_ff.an_en)
        else $error("disable did not force mode");

    chk_pdn_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pdn_reset_i && s_ff.an_en && !ctrl_wr |=> s_ff.st == ST_ABIL && !s_ff.link)
        else $error("power-down reset did not restart");

endmodule // an_pd_ctrl

// ---- rtl/an_pd_pkg.sv ----
// shared constants for the auto-negotiation and parallel-detection block
package an_pd_pkg;
    // register numbers on the management port
    localparam logic [4:0]  REG_CTRL   = 5'h00;
    localparam logic [4:0]  REG_STAT   = 5'h01;
    localparam logic [4:0]  REG_ADV    = 5'h04;
    localparam logic [4:0]  REG_LPA    = 5'h05;
    localparam logic [4:0]  REG_EXP    = 5'h06;
    localparam logic [4:0]  REG_SPEC   = 5'h1F;
    // control register fields
    localparam int          CTRL_SRST  = 15;
    localparam int          CTRL_SPD   = 13;
    localparam int          CTRL_ANEN  = 12;
    localparam int          CTRL_RSTRT = 9;
    localparam int          CTRL_DPX   = 8;
    // status, expansion and special status fields
    localparam int          STAT_ANDONE = 5;
    localparam int          STAT_ANABLE = 3;
    localparam int          STAT_LINK   = 2;
    localparam int          EXP_LPAN    = 0;
    localparam int          EXP_PDF     = 4;
    localparam int          SPEC_DONE   = 12;
    localparam int          SPEC_IND_LO = 2;
    // link code word layout
    localparam int          LCW_ACK    = 14;
    localparam int          LCW_TA_LO  = 5;
    localparam logic [4:0]  SEL_8023   = 5'h01;
    localparam logic [3:0]  TA_10HD    = 4'h1;
    localparam logic [3:0]  TA_100HD   = 4'h4;
    // reset values
    localparam logic [3:0]  ADV_RST    = 4'hF;
    localparam logic        ANEN_RST   = 1'b1;
    localparam logic        SPD_RST    = 1'b1;
    localparam logic        DPX_RST    = 1'b1;
    // burst layout and identical-word match count
    localparam int          BURST_SLOTS = 33;
    localparam int          MATCH_NEED  = 3;
    // timing
    localparam int          CLK_NS      = 40;
    localparam int          SLOT_NS     = 62500;
    localparam int          BURST_MS    = 16;
    localparam int          BREAK_MS    = 1200;
    localparam int          TIMEOUT_MS  = 50;
    localparam int          SLOT_CYC    = SLOT_NS / CLK_NS;
    localparam int          BURST_CYC   = BURST_MS * 1000000 / CLK_NS;
    localparam int          BREAK_CYC   = BREAK_MS * 1000000 / CLK_NS;
    localparam int          TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_NS;
    // negotiation states
    typedef enum logic [2:0] {
        ST_FORCED = 3'b000,
        ST_BREAK  = 3'b001,
        ST_ABIL   = 3'b010,
        ST_ACK    = 3'b011,
        ST_LINK   = 3'b100
    } an_st_type;
endpackage

// ---- sim/link_partner.sv ----
// remote link partner model: decoded code words and line detect levels
`timescale 1ns/100ps
module link_partner (
    input  wire logic        clk_i,
    output logic             word_valid_o,
    output logic [15:0]      word_o,
    output logic             nlp_o,
    output logic             mlt3_o,
    output logic             signal_o
);
    initial begin
        word_valid_o = 1'b0;
        word_o       = 16'h0000;
        nlp_o        = 1'b0;
        mlt3_o       = 1'b0;
        signal_o     = 1'b1;
    end
    // base word only, no next page; between words the inverse stands so a stale word never looks fresh
    task automatic send(input logic [15:0] w);
        @(posedge clk_i);
        word_valid_o <= 1'b1;
        word_o       <= w;
        @(posedge clk_i);
        word_valid_o <= 1'b0;
        word_o       <= ~w;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic detect(input logic n, input logic m);
        @(posedge clk_i);
        nlp_o  <= n;
        mlt3_o <= m;
    endtask
    // one cycle of signal loss, as a cable glitch would give
    task automatic drop();
        @(posedge clk_i);
        signal_o <= 1'b0;
        @(posedge clk_i);
        signal_o <= 1'b1;
    endtask
endmodule // link_partner

// ---- sim/tb_an_pd_ctrl.sv ----
// testbench of the negotiation and parallel detection block
`timescale 1ns/100ps
module tb_an_pd_ctrl;
    import an_pd_pkg::*;
    logic clk_i, resetn_i, pdn_reset_i, wr_i, rd_i, tx_en_i, rx_active_i;
    logic [4:0]  addr_i;
    logic [15:0] wdata_i, rdata_o, rx_word_i;
    logic rx_word_valid_i, nlp_detect_i, mlt3_detect_i, rx_signal_i;
    logic tx_pulse_o, link_up_o, speed100_o, full_duplex_o, an_done_o, crs_o, col_o;
    int error_cnt = 0;
    int n_compared = 0;
    int n_pulse = 0;
    int p0 = 0;
    logic [3:0] ta_t [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [2:0] ind_t [4] = '{3'h6, 3'h2, 3'h5, 3'h1};
    an_pd_ctrl #(.BREAK_CYCLES(100), .BURST_CYCLES(200), .TIMEOUT_CYCLES(2000)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .pdn_reset_i(pdn_reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_word_valid_i(rx_word_valid_i), .rx_word_i(rx_word_i), .nlp_detect_i(nlp_detect_i),
        .mlt3_detect_i(mlt3_detect_i), .rx_signal_i(rx_signal_i), .tx_en_i(tx_en_i),
        .rx_active_i(rx_active_i), .tx_pulse_o(tx_pulse_o), .link_up_o(link_up_o), .speed100_o(speed100_o),
        .full_duplex_o(full_duplex_o), .an_done_o(an_done_o), .crs_o(crs_o), .col_o(col_o));
    link_partner i_lp (.clk_i(clk_i), .word_valid_o(rx_word_valid_i), .word_o(rx_word_i),
        .nlp_o(nlp_detect_i), .mlt3_o(mlt3_detect_i), .signal_o(rx_signal_i));
    // short burst period: only the leading framing pulse of each burst fits
    always @(posedge clk_i) if (tx_pulse_o) n_pulse++;
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look just after that edge
    task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o & m, e);
    endtask
    task automatic mode(input logic l, input logic s, input logic f);
        #1 chk({13'h0, link_up_o, speed100_o, full_duplex_o}, {13'h0, l, s, f});
    endtask
    task automatic nego(input logic [3:0] ta);
        repeat (3) i_lp.send({7'h00, ta, SEL_8023});
        repeat (3) i_lp.send({7'h20, ta, SEL_8023});
    endtask
    task automatic act(input logic tx, input logic rx, input logic c, input logic k);
        @(posedge clk_i);
        tx_en_i     <= tx;
        rx_active_i <= rx;
        repeat (2) @(posedge clk_i);
        #1 chk({14'h0, crs_o, col_o}, {14'h0, c, k});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        error_cnt++;
        test_done();
    end
    initial begin
        {resetn_i, pdn_reset_i, wr_i, rd_i, tx_en_i, rx_active_i} = 6'h00;
        addr_i  = 5'h00;
        wdata_i = 16'h0000;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdc(REG_CTRL, 16'hFFFF, 16'h3100);
        rdc(REG_ADV, 16'h01FF, 16'h01E1);
        rdc(REG_STAT, 16'h0008, 16'h0008);
        repeat (250) @(posedge clk_i);
        chk(n_pulse[15:0], 16'h0001);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) begin
                i_lp.drop();
                mode(1'b0, (i < 3), i[0]);
            end
            nego(ta_t[i]);
            mode(1'b1, (i < 2), ~i[0]);
            chk({15'h0, an_done_o}, 16'h0001);
            rdc(REG_SPEC, 16'h101C, {3'h0, 1'b1, 7'h00, ind_t[i], 2'h0});
            rdc(REG_LPA, 16'hFFFF, {7'h00, ta_t[i], SEL_8023});
        end
        wr(REG_ADV, 16'h0060);
        repeat (3) @(posedge clk_i);
        mode(1'b1, 1'b0, 1'b0);
        rdc(REG_ADV, 16'h01FF, 16'h0061);
        wr(REG_CTRL, 16'h1200);
        p0 = n_pulse;
        repeat (40) @(posedge clk_i);
        mode(1'b0, 1'b0, 1'b0);
        chk(16'(n_pulse - p0), 16'h0000);
        rdc(REG_CTRL, 16'h0200, 16'h0000);
        repeat (70) @(posedge clk_i);
        nego(4'hF);
        mode(1'b1, 1'b0, 1'b1);
        i_lp.drop();
        i_lp.detect(1'b1, 1'b1);
        repeat (3) @(posedge clk_i);
        i_lp.detect(1'b0, 1'b0);
        rdc(REG_EXP, 16'h0010, 16'h0010);
        i_lp.detect(1'b0, 1'b1);
        repeat (3) @(posedge clk_i);
        mode(1'b1, 1'b1, 1'b0);
        rdc(REG_EXP, 16'h0011, 16'h0000);
        wr(REG_CTRL, 16'h2000);
        repeat (2) @(posedge clk_i);
        mode(1'b1, 1'b1, 1'b0);
        act(1'b1, 1'b0, 1'b1, 1'b0);
        act(1'b1, 1'b1, 1'b1, 1'b1);
        wr(REG_CTRL, 16'h0100);
        repeat (2) @(posedge clk_i);
        mode(1'b1, 1'b0, 1'b1);
        act(1'b1, 1'b0, 1'b0, 1'b0);
        act(1'b1, 1'b1, 1'b1, 1'b0);
        act(1'b0, 1'b0, 1'b0, 1'b0);
        i_lp.detect(1'b0, 1'b0);
        wr(REG_ADV, 16'h0100);
        wr(REG_CTRL, 16'h1000);
        repeat (3) i_lp.send({7'h00, 4'hF, SEL_8023});
        i_lp.send({7'h20, 4'h7, SEL_8023});
        repeat (2) i_lp.send({7'h20, 4'hF, SEL_8023});
        mode(1'b0, 1'b0, 1'b1);
        nego(4'h8);
        mode(1'b1, 1'b1, 1'b1);
        @(posedge clk_i);
        pdn_reset_i <= 1'b1;
        @(posedge clk_i);
        pdn_reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        mode(1'b0, 1'b1, 1'b1);
        wr(REG_CTRL, 16'h8000);
        rdc(REG_CTRL, 16'h3300, 16'h3100);
        rdc(REG_ADV, 16'h01FF, 16'h01E1);
        test_done();
    end
endmodule // tb_an_pd_ctrl
